// ### rtl/cpw_pwm_unit.sv
// PWM generator with 8-bit timebase, period register and double-buffered 10-bit duty.
// Assumes an APB master on clk_sys; the pin mux with the port latch sits outside.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module cpw_pwm_unit (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire cpw_pkg::cpw_apb_req_s apb_req,
    output cpw_pkg::cpw_apb_rsp_s apb_rsp,
    output logic pwm_output_pin,
    output logic timebase_event,
    output logic postscaled_event
);
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] control;
        logic [7:0] duty_high_byte;
        logic [7:0] duty_shadow;
        logic [1:0] duty_latch;
        logic [7:0] unit_control;
        logic [7:0] period_limit;
        logic [3:0] post_cnt;
        logic pin;
        logic tb_evt;
        logic post_evt;
        logic post_sticky;
        logic [31:0] rdata;
    } cpw_state_s;

    cpw_state_s st_q;
    cpw_state_s st_d;
    logic inc_tick;
    logic [1:0] frac;
    logic pwm_mode;
    logic unit_off;
    logic run;
    logic [7:0] idx;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [9:0] duty_active;
    logic [9:0] time_now;
    logic at_limit;
    logic [7:0] next_count;

    // Register index from byte address; only aligned words decode
    function automatic logic [7:0] reg_index(input logic [11:0] a);
        reg_index = a[9:2];
    endfunction

    assign idx = reg_index(apb_req.paddr);
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign mapped = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0)
        && (idx == cpw_pkg::IDX_TIMEBASE_COUNT || idx == cpw_pkg::IDX_TIMEBASE_CONTROL
        || idx == cpw_pkg::IDX_DUTY_HIGH_BYTE || idx == cpw_pkg::IDX_DUTY_SHADOW
        || idx == cpw_pkg::IDX_UNIT_CONTROL || idx == cpw_pkg::IDX_PERIOD_LIMIT
        || idx == cpw_pkg::IDX_STATUS);

    // Mode decode
    assign pwm_mode = (st_q.unit_control[3:2] == 2'b11);
    assign unit_off = (st_q.unit_control[3:0] == 4'h0);
    assign run = st_q.control[cpw_pkg::TBC_RUN_BIT];

    // Prescaler drives counter increments and the two fraction bits
    cpw_prescaler u_pre (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .run(run),
        .sel(st_q.control[1:0]),
        .tick(inc_tick),
        .frac(frac)
    );

    // Buffered duty against counter extended by fraction bits
    assign duty_active = {st_q.duty_shadow, st_q.duty_latch};
    // Time of the next cycle, so the registered pin falls exactly at the match
    assign at_limit = (st_q.count == st_q.period_limit);
    assign next_count = at_limit ? 8'h00 : st_q.count + 8'h01;
    assign time_now = {(inc_tick ? next_count : st_q.count), frac};

    // Next state: bus writes, timebase, duty buffering and pin
    always_comb begin
        st_d = st_q;
        st_d.tb_evt = 1'b0;
        st_d.post_evt = 1'b0;
        // Timebase counts up; match arms a clear on the next increment
        if (inc_tick) begin
            if (at_limit) begin
                st_d.count = 8'h00;
                st_d.tb_evt = 1'b1;
                // Postscaler divides match events only
                if (st_q.post_cnt == st_q.control[6:3]) begin
                    st_d.post_cnt = 4'h0;
                    st_d.post_evt = 1'b1;
                    st_d.post_sticky = 1'b1;
                end else begin
                    st_d.post_cnt = st_q.post_cnt + 4'h1;
                end
                if (pwm_mode) begin
                    st_d.duty_shadow = st_q.duty_high_byte;
                    st_d.duty_latch = st_q.unit_control[5:4];
                    // Zero duty leaves the pin low
                    st_d.pin = ({st_q.duty_high_byte, st_q.unit_control[5:4]} != 10'h000);
                end
            end else begin
                st_d.count = next_count;
            end
        end
        // Clear at the duty match; never reached when on-time exceeds period
        if (pwm_mode && run && time_now == duty_active && !(inc_tick && at_limit)) begin
            st_d.pin = 1'b0;
        end
        if (!pwm_mode) begin
            st_d.pin = 1'b0;
        end
        // Register writes, taken at the access edge
        if (wr_acc && mapped) begin
            case (idx)
                cpw_pkg::IDX_TIMEBASE_COUNT: begin
                    st_d.count = apb_req.pwdata[7:0];
                end
                cpw_pkg::IDX_TIMEBASE_CONTROL: st_d.control = apb_req.pwdata[7:0] & cpw_pkg::TBC_MASK;
                cpw_pkg::IDX_DUTY_HIGH_BYTE: st_d.duty_high_byte = apb_req.pwdata[7:0];
                cpw_pkg::IDX_DUTY_SHADOW: begin
                    if (!pwm_mode) begin
                        st_d.duty_shadow = apb_req.pwdata[7:0];
                    end
                end
                cpw_pkg::IDX_UNIT_CONTROL: begin
                    st_d.unit_control = apb_req.pwdata[7:0] & cpw_pkg::UC_MASK;
                    if (apb_req.pwdata[3:0] == 4'h0) begin
                        st_d.pin = 1'b0;
                        st_d.duty_latch = 2'h0;
                    end
                end
                cpw_pkg::IDX_PERIOD_LIMIT: st_d.period_limit = apb_req.pwdata[7:0];
                cpw_pkg::IDX_STATUS: begin
                    // Write one clears; a new event wins
                    if (apb_req.pwdata[0] && !st_d.post_evt) begin
                        st_d.post_sticky = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (unit_off) begin
            st_d.pin = 1'b0;
        end
        // Read data captured in the setup cycle, presented in the access cycle
        if (rd_acc) begin
            st_d.rdata = 32'h0000_0000;
            case (idx)
                cpw_pkg::IDX_TIMEBASE_COUNT: st_d.rdata[7:0] = st_q.count;
                cpw_pkg::IDX_TIMEBASE_CONTROL: st_d.rdata[7:0] = st_q.control;
                cpw_pkg::IDX_DUTY_HIGH_BYTE: st_d.rdata[7:0] = st_q.duty_high_byte;
                cpw_pkg::IDX_DUTY_SHADOW: st_d.rdata[7:0] = st_q.duty_shadow;
                cpw_pkg::IDX_UNIT_CONTROL: st_d.rdata[7:0] = st_q.unit_control;
                cpw_pkg::IDX_PERIOD_LIMIT: st_d.rdata[7:0] = st_q.period_limit;
                cpw_pkg::IDX_STATUS: st_d.rdata[1:0] = {st_q.pin, st_q.post_sticky};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.count <= cpw_pkg::RST_TIMEBASE_COUNT;
            st_q.control <= cpw_pkg::RST_TIMEBASE_CONTROL;
            st_q.unit_control <= cpw_pkg::RST_UNIT_CONTROL;
            st_q.period_limit <= cpw_pkg::RST_PERIOD_LIMIT;
            st_q.duty_high_byte <= cpw_pkg::RST_DUTY;
            st_q.duty_shadow <= cpw_pkg::RST_DUTY;
        end else begin
            st_q <= st_d;
        end
    end

    // Bus answer: one wait-free access phase; unmapped addresses give an error
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
    assign apb_rsp.prdata = st_q.rdata;
    assign pwm_output_pin = st_q.pin;
    assign timebase_event = st_q.tb_evt;
    assign postscaled_event = st_q.post_evt;

    // Helper history for assertions
    logic prev_match_tick;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev_match_tick <= 1'b0;
        end else begin
            prev_match_tick <= inc_tick && at_limit;
        end
    end

    sequence rollover_s;
        inc_tick && at_limit && !wr_acc;
    endsequence

    count_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rollover_s |=> (st_q.count == 8'h00 && timebase_event))
        else $error("counter not cleared at rollover");
    shadow_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rollover_s and pwm_mode |=> st_q.duty_shadow == $past(st_q.duty_high_byte))
        else $error("duty shadow not loaded at rollover");
    zero_duty_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rollover_s and pwm_mode
        and ({st_q.duty_high_byte, st_q.unit_control[5:4]} == 10'h000) |=> !pwm_output_pin)
        else $error("pin set with zero duty");
    pin_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rollover_s and pwm_mode and !unit_off
        and ({st_q.duty_high_byte, st_q.unit_control[5:4]} != 10'h000) |=> pwm_output_pin)
        else $error("pin not set at rollover");
    shadow_ro_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_acc && idx == cpw_pkg::IDX_DUTY_SHADOW && pwm_mode && !inc_tick
        |=> $stable(st_q.duty_shadow))
        else $error("duty shadow written in PWM mode");
    duty_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        pwm_mode && run && time_now == duty_active && !(inc_tick && at_limit)
        |=> !pwm_output_pin)
        else $error("pin not cleared at duty match");
    off_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_acc && idx == cpw_pkg::IDX_UNIT_CONTROL && apb_req.pwdata[3:0] == 4'h0
        |=> !pwm_output_pin ##1 !pwm_output_pin)
        else $error("pin not low after unit off");
    non_pwm_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !pwm_mode |=> !pwm_output_pin)
        else $error("pin high outside PWM mode");
    period_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        inc_tick && !at_limit && !wr_acc |=> st_q.count == $past(st_q.count) + 8'h01)
        else $error("counter did not increment");
    post_evt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        postscaled_event |-> timebase_event && prev_match_tick)
        else $error("postscaled event without match");
endmodule // cpw_pwm_unit

// ### rtl/cpw_pkg.sv
// Package for the PWM generator: register map, field layout, reset values, types.
// Assumes a 32-bit APB slave; register indices map to byte addresses times four.
package cpw_pkg;
    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_TIMEBASE_COUNT = 8'h11;
    localparam logic [7:0] IDX_TIMEBASE_CONTROL = 8'h12;
    localparam logic [7:0] IDX_DUTY_HIGH_BYTE = 8'h15;
    localparam logic [7:0] IDX_DUTY_SHADOW = 8'h16;
    localparam logic [7:0] IDX_UNIT_CONTROL = 8'h17;
    localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;
    localparam logic [7:0] IDX_STATUS = 8'h18;
    localparam int ADDR_SHIFT = 2;
    // Field positions of timebase_control
    localparam int TBC_PRESCALE_LSB = 0;
    localparam int TBC_RUN_BIT = 2;
    localparam int TBC_POSTSCALE_LSB = 3;
    localparam logic [7:0] TBC_MASK = 8'h7F;
    // Field positions of unit_control
    localparam int UC_MODE_LSB = 0;
    localparam int UC_DUTY_LSB = 4;
    localparam logic [7:0] UC_MASK = 8'h3F;
    // Reset values
    localparam logic [7:0] RST_TIMEBASE_COUNT = 8'h00;
    localparam logic [7:0] RST_TIMEBASE_CONTROL = 8'h00;
    localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
    localparam logic [7:0] RST_DUTY = 8'h00;
    // Prescale selections
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    // Clock: 40 MHz system clock, four phases per instruction clock
    localparam int CLK_HZ = 40000000;
    localparam int PHASES_PER_INSTR = 4;

    typedef enum logic [1:0] {
        CPW_IDLE = 2'b00,
        CPW_SETUP = 2'b01,
        CPW_ACCESS = 2'b11
    } cpw_bus_e;

    // APB request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cpw_apb_req_s;

    // APB answer carrier
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cpw_apb_rsp_s;
endpackage

// ### rtl/cpw_prescaler.sv
// Timebase prescaler: phase counter giving the timebase increment tick and fraction bits.
// Assumes one system clock domain and synchronous clear from the unit.
`timescale 1ns/1ps
module cpw_prescaler (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic run,
    input wire logic [1:0] sel,
    output logic tick,
    output logic [1:0] frac
);
    typedef struct packed {
        logic [5:0] cnt;
    } cpw_pre_s;
    cpw_pre_s st_q;
    cpw_pre_s st_d;
    logic [5:0] last;

    // Terminal count of phases: 4 x 1, 4 x 4 or 4 x 16
    always_comb begin
        case (sel)
            cpw_pkg::PRE_DIV1: last = 6'h03;
            cpw_pkg::PRE_DIV4: last = 6'h0F;
            default: last = 6'h3F;
        endcase
    end

    // Increment tick at the wrap
    // Fraction is the top two bits of the next phase count, for full 10-bit resolution
    always_comb begin
        st_d = st_q;
        if (!run) begin
            st_d.cnt = 6'h00;
        end else if (st_q.cnt >= last) begin
            st_d.cnt = 6'h00;
        end else begin
            st_d.cnt = st_q.cnt + 6'h01;
        end
    end
    assign tick = run && (st_q.cnt >= last);
    always_comb begin
        case (sel)
            cpw_pkg::PRE_DIV1: frac = st_d.cnt[1:0];
            cpw_pkg::PRE_DIV4: frac = st_d.cnt[3:2];
            default: frac = st_d.cnt[5:4];
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // cpw_prescaler

// ### verification/cpw_pwm_load.sv
// Load on the PWM pin, with the port pin multiplexer in front of it and a cycle meter.
// Assumes the pad has a pull-down, so a pin left as an input reads low.
`timescale 1ns/1ps
module cpw_pwm_load (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pwm_output_pin,
    input wire logic port_dir_in,
    output logic [31:0] high_total,
    output logic [31:0] cycle_total
);
    logic pad;

    // Pad follows the PWM latch only while the direction bit makes it an output
    assign pad = port_dir_in ? 1'b0 : pwm_output_pin;

    // Running totals of cycles and of cycles with the pad high
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            high_total <= 32'h0;
            cycle_total <= 32'h0;
        end else begin
            cycle_total <= cycle_total + 32'h1;
            high_total <= high_total + {31'h0, pad};
        end
    end
endmodule // cpw_pwm_load

// ### verification/tb_cpw_pwm_unit.sv
// Testbench for the PWM unit: register table, waveform rows, refusals and postscaler.
// Assumes the load model on the pin and the zero-wait APB slave of the design.
`timescale 1ns/1ps
module tb_cpw_pwm_unit;
    typedef struct packed {
        logic [7:0] per;
        logic [1:0] pre;
        logic [3:0] mode;
        logic [9:0] duty;
        logic [31:0] eper;
        logic [31:0] ehigh;
    } cpw_row_s;
    localparam int LIMIT = 30000;
    logic clk_sys;
    logic rstn;
    cpw_pkg::cpw_apb_req_s apb_req;
    cpw_pkg::cpw_apb_rsp_s apb_rsp;
    logic pwm_output_pin;
    logic timebase_event;
    logic postscaled_event;
    logic port_dir_in;
    logic [31:0] high_total;
    logic [31:0] cycle_total;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    cpw_row_s rows [9];
    logic [7:0] ridx [6];
    logic [31:0] rexp [6];

    cpw_pwm_unit cpw_pwm_unit_inst (.clk_sys(clk_sys), .rstn(rstn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .pwm_output_pin(pwm_output_pin),
        .timebase_event(timebase_event), .postscaled_event(postscaled_event));
    cpw_pwm_load cpw_pwm_load_inst (.clk_sys(clk_sys), .rstn(rstn),
        .pwm_output_pin(pwm_output_pin), .port_dir_in(port_dir_in),
        .high_total(high_total), .cycle_total(cycle_total));

    // Clock at 40 MHz
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            test_done();
        end
    end

    task automatic test_done();
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= {2'h0, idx, 2'h0};
        apb_req.pwdata <= wd;
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic w(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rc(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        check(name, r, exp);
    endtask

    // Wait for a rollover pulse or a postscaled pulse
    task automatic wait_ev(input logic post);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((post ? postscaled_event : timebase_event) !== 1'b1 && n < 3000);
    endtask

    // Cycles and high cycles of one whole period, after one settling period
    task automatic measure(output logic [31:0] per, output logic [31:0] hi);
        logic [31:0] c0;
        logic [31:0] h0;
        wait_ev(1'b0);
        wait_ev(1'b0);
        c0 = cycle_total;
        h0 = high_total;
        wait_ev(1'b0);
        per = cycle_total - c0;
        hi = high_total - h0;
    endtask

    initial begin
        logic [31:0] rd;
        logic [31:0] per;
        logic [31:0] hi;
        logic err;
        int n;
        rstn = 1'b0;
        apb_req = '0;
        port_dir_in = 1'b1;
        rows = '{'{8'h03, 2'h0, 4'hC, 10'h005, 32'h10, 32'h05},
                 '{8'h03, 2'h0, 4'hD, 10'h000, 32'h10, 32'h00},
                 '{8'h03, 2'h0, 4'hE, 10'h3FF, 32'h10, 32'h10},
                 '{8'h01, 2'h1, 4'hF, 10'h003, 32'h20, 32'h0C},
                 '{8'h01, 2'h2, 4'hC, 10'h002, 32'h80, 32'h20},
                 '{8'h00, 2'h3, 4'hD, 10'h001, 32'h40, 32'h10},
                 '{8'h07, 2'h0, 4'hE, 10'h01F, 32'h20, 32'h1F},
                 '{8'h03, 2'h0, 4'h8, 10'h005, 32'h10, 32'h00},
                 '{8'h07, 2'h0, 4'hF, 10'h020, 32'h20, 32'h20}};
        ridx = '{cpw_pkg::IDX_TIMEBASE_COUNT, cpw_pkg::IDX_TIMEBASE_CONTROL,
                 cpw_pkg::IDX_DUTY_HIGH_BYTE, cpw_pkg::IDX_DUTY_SHADOW,
                 cpw_pkg::IDX_UNIT_CONTROL, cpw_pkg::IDX_PERIOD_LIMIT};
        rexp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF};
        repeat (2) @(posedge clk_sys);
        check("pin in reset", {31'h0, pwm_output_pin}, 32'h0);
        rstn <= 1'b1;
        // Reset values of the register table
        for (int i = 0; i < 6; i++) begin
            rc("reset value", ridx[i], rexp[i]);
        end
        apb(1'b0, 8'h00, 32'h0, rd, err);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        // Waveform rows, programmed in the documented set-up order
        for (int i = 0; i < 9; i++) begin
            w(cpw_pkg::IDX_PERIOD_LIMIT, {24'h0, rows[i].per});
            w(cpw_pkg::IDX_DUTY_HIGH_BYTE, {24'h0, rows[i].duty[9:2]});
            port_dir_in <= 1'b0;
            w(cpw_pkg::IDX_TIMEBASE_CONTROL, {29'h0, 1'b1, rows[i].pre});
            w(cpw_pkg::IDX_UNIT_CONTROL, {26'h0, rows[i].duty[1:0], rows[i].mode});
            measure(per, hi);
            check("period cycles", per, rows[i].eper);
            check("high cycles", hi, rows[i].ehigh);
        end
        // Duty written mid-period waits for rollover; shadow ignores writes
        wait_ev(1'b0);
        w(cpw_pkg::IDX_DUTY_HIGH_BYTE, 32'h1);
        w(cpw_pkg::IDX_DUTY_SHADOW, 32'hAB);
        rc("shadow before rollover", cpw_pkg::IDX_DUTY_SHADOW, 32'h8);
        wait_ev(1'b0);
        rc("shadow after rollover", cpw_pkg::IDX_DUTY_SHADOW, 32'h1);
        measure(per, hi);
        check("high cycles new duty", hi, 32'h4);
        // Postscaler divides events, not the PWM period
        w(cpw_pkg::IDX_TIMEBASE_CONTROL, 32'h14);
        wait_ev(1'b1);
        n = 0;
        do begin
            @(posedge clk_sys);
            if (timebase_event === 1'b1) n++;
        end while (postscaled_event !== 1'b1 && n < 10);
        check("events per postscaled", 32'(n), 32'h3);
        measure(per, hi);
        check("period with postscaler", per, 32'h20);
        // Clearing unit control while the pin is high
        w(cpw_pkg::IDX_DUTY_HIGH_BYTE, 32'h7);
        w(cpw_pkg::IDX_UNIT_CONTROL, 32'hFF);
        rc("unit control mask", cpw_pkg::IDX_UNIT_CONTROL, 32'h3F);
        wait_ev(1'b0);
        wait_ev(1'b0);
        w(cpw_pkg::IDX_UNIT_CONTROL, 32'h0);
        repeat (2) @(posedge clk_sys);
        check("pin after clear", {31'h0, pwm_output_pin}, 32'h0);
        measure(per, hi);
        check("high cycles off", hi, 32'h0);
        w(cpw_pkg::IDX_TIMEBASE_CONTROL, 32'hFF);
        rc("control mask", cpw_pkg::IDX_TIMEBASE_CONTROL, 32'h7F);
        // Second reset in mid-run
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("pin in second reset", {31'h0, pwm_output_pin}, 32'h0);
        rstn <= 1'b1;
        rc("period after reset", cpw_pkg::IDX_PERIOD_LIMIT, 32'hFF);
        test_done();
    end
endmodule // tb_cpw_pwm_unit
